// >>> design/vmccc_cls_check.sv
// Checker: per-bit allowed 0/1 test of one control vector
`default_nettype none
module vmccc_cls_check (
	// Class data
	vmccc_cls_if.chk c
);
	logic [31:0] bad0;
	logic [31:0] bad1;
	logic [31:0] bad_d1;
	genvar       x;
	generate
		for (x = 0; x < 32; x++) begin : g_bit
			assign bad0[x]   = !c.ctl[x] && c.cap[x];
			assign bad1[x]   = c.ctl[x] && !c.cap[vmccc_pkg::ALLOW1_LSB + x];
			assign bad_d1[x] = !c.true_en && c.def1[x] && !c.ctl[x];
		end
	endgenerate
	assign c.bad  = c.gate ? (bad0 | bad1 | bad_d1) : 32'h0000_0000;
	assign c.fail = |c.bad;
endmodule
`default_nettype wire

// >>> design/vmccc_cls_if.sv
// Interface: one control class handed to the class checker
`default_nettype none
interface vmccc_cls_if;
	logic [31:0] ctl;
	logic [63:0] cap;
	logic [31:0] def1;
	logic        true_en;
	logic        gate;
	logic        fail;
	logic [31:0] bad;
	modport chk (input ctl, input cap, input def1, input true_en, input gate, output fail, output bad);
	modport top (output ctl, output cap, output def1, output true_en, output gate, input fail, input bad);
endinterface
`default_nettype wire

// >>> design/vmccc_pkg.sv
// Package: register indices, field layouts and default-one masks
`default_nettype none
package vmccc_pkg;
	localparam int          IDX_W            = 12;
	localparam int          CAP_W            = 64;
	localparam int          CTL_W            = 32;
	localparam logic [11:0] IDX_PIN          = 12'h481;
	localparam logic [11:0] IDX_PRIMARY      = 12'h482;
	localparam logic [11:0] IDX_EXIT         = 12'h483;
	localparam logic [11:0] IDX_SECONDARY    = 12'h48b;
	localparam logic [11:0] IDX_TRUE_PIN     = 12'h48d;
	localparam logic [11:0] IDX_TRUE_PRIMARY = 12'h48e;
	localparam logic [11:0] IDX_TRUE_EXIT    = 12'h48f;
	localparam int          ALLOW1_LSB       = 32;
	localparam int          ACT_SEC_BIT      = 31;
	localparam int          PRI_SEC_ALLOW    = 63;
	localparam int          TRUE_CTL_BIT     = 55;
	// Default-one class members per control class
	localparam logic [31:0] PIN_DEF1         = 32'h0000_0016;
	localparam logic [31:0] PRI_DEF1         = 32'h0401_e172;
	localparam logic [31:0] EXIT_DEF1        = 32'h0003_6dff;
	localparam logic [31:0] GP_ERR_CODE      = 32'h0000_0000;
	// Check classes, one per control vector
	localparam int          NCLS             = 4;
	localparam int          CLS_PIN          = 0;
	localparam int          CLS_PRI          = 1;
	localparam int          CLS_SEC          = 2;
	localparam int          CLS_EXIT         = 3;
	localparam int          RD_LAT           = 1;
	localparam int          CHK_LAT          = 2;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CHECK = 2'b01,
		ST_DONE  = 2'b10
	} vmccc_state_e;
endpackage
`default_nettype wire

// >>> design/vmccc_top.sv
// Top: capability registers and entry control-vector checker
// Function
// - Entry fails when control is 0 but its allowed-zero bit reads 1.
// - Entry fails when control is 1 but bit 32+X reads 0.
// - Pin capability at 481h; default-one bits 1, 2, 4 read 1.
// - Without true controls, any cleared default-one pin control fails entry.
// - With true controls, true pin capability at 48Dh, no forced ones.
// - Primary capability at 482h; default-one bits always read 1.
// - Without true controls, any cleared default-one primary control fails entry.
// - With true controls, true primary capability at 48Eh, no exceptions.
// - Secondary capability at 48Bh; low 32 bits read 0.
// - Reserved secondary controls never report an allowed one-setting.
// - Secondary fails only when activate-secondary is also set.
// - Secondary capability exists only when primary bit 63 reads 1.
// - Exit capability at 483h; default-one bits always read 1.
// - Without true controls, any cleared default-one exit control fails entry.
// - With true controls, true exit capability at 48Fh.
// - Pin capability readable at 481h.
// - Primary capability readable at 482h.
// - Writes, or reads without extension support, raise protection fault code 0.
// - True-controls flag is basic capability bit 55; here it is the registered TRUE_CTL_I strap.
`default_nettype none
module vmccc_top #(
	parameter logic [63:0] PIN_CAP      = 64'h0000_007f_0000_0016,
	parameter logic [63:0] PRI_CAP      = 64'hfff9_fffe_0401_e172,
	parameter logic [63:0] SEC_CAP      = 64'h0000_00ff_0000_0000,
	parameter logic [63:0] EXIT_CAP     = 64'h003f_ffff_0003_6dff,
	parameter logic [63:0] TRUE_PIN     = 64'h0000_007f_0000_0000,
	parameter logic [63:0] TRUE_PRI     = 64'hfff9_fffe_0000_0000,
	parameter logic [63:0] TRUE_EXIT    = 64'h003f_ffff_0000_0000,
	parameter logic [31:0] SEC_RSVD     = 32'hffff_ff00
) (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	// Configuration straps
	input  wire logic        EXT_SUPPORT_I,
	input  wire logic        TRUE_CTL_I,
	// Capability register access
	input  wire logic        RD_I,
	input  wire logic        WR_I,
	input  wire logic [11:0] IDX_I,
	output logic      [63:0] RD_DATA_O,
	output logic             RD_VALID_O,
	output logic             GP_FAULT_O,
	output logic      [31:0] GP_CODE_O,
	// Entry check request
	input  wire logic        ENTRY_REQ_I,
	input  wire logic [31:0] PIN_CTL_I,
	input  wire logic [31:0] PRI_CTL_I,
	input  wire logic [31:0] SEC_CTL_I,
	input  wire logic [31:0] EXIT_CTL_I,
	output logic             ENTRY_DONE_O,
	output logic             ENTRY_FAIL_O,
	output logic      [3:0]  FAIL_CLASS_O,
	output logic             BUSY_O
);
	vmccc_cls_if           cls [vmccc_pkg::NCLS] ();
	vmccc_pkg::vmccc_state_e state_r;
	logic [63:0]           pin_cap;
	logic [63:0]           pri_cap;
	logic [63:0]           sec_cap;
	logic [63:0]           exit_cap;
	logic [63:0]           rd_mux;
	logic                  rd_hit;
	logic                  true_r;
	logic [31:0]           pin_ctl_r;
	logic [31:0]           pri_ctl_r;
	logic [31:0]           sec_ctl_r;
	logic [31:0]           exit_ctl_r;
	logic [3:0]            fail_vec;

	assign pin_cap  = {PIN_CAP[63:32], PIN_CAP[31:0] | vmccc_pkg::PIN_DEF1};
	assign pri_cap  = {PRI_CAP[63:32], PRI_CAP[31:0] | vmccc_pkg::PRI_DEF1};
	assign sec_cap  = {SEC_CAP[63:32] & ~SEC_RSVD, 32'h0000_0000};
	assign exit_cap = {EXIT_CAP[63:32], EXIT_CAP[31:0] | vmccc_pkg::EXIT_DEF1};

	// Read decode; unsupported indices fault like absent registers
	always_comb begin
		rd_mux = 64'h0000_0000_0000_0000;
		rd_hit = 1'b0;
		case (IDX_I)
			vmccc_pkg::IDX_PIN: begin
				rd_mux = pin_cap;
				rd_hit = 1'b1;
			end
			vmccc_pkg::IDX_PRIMARY: begin
				rd_mux = pri_cap;
				rd_hit = 1'b1;
			end
			vmccc_pkg::IDX_EXIT: begin
				rd_mux = exit_cap;
				rd_hit = 1'b1;
			end
			vmccc_pkg::IDX_SECONDARY: begin
				rd_mux = sec_cap;
				rd_hit = pri_cap[vmccc_pkg::PRI_SEC_ALLOW];
			end
			vmccc_pkg::IDX_TRUE_PIN: begin
				rd_mux = TRUE_PIN;
				rd_hit = true_r;
			end
			vmccc_pkg::IDX_TRUE_PRIMARY: begin
				rd_mux = TRUE_PRI;
				rd_hit = true_r;
			end
			vmccc_pkg::IDX_TRUE_EXIT: begin
				rd_mux = TRUE_EXIT;
				rd_hit = true_r;
			end
			default: begin
				rd_mux = 64'h0000_0000_0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Register read answer
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			RD_DATA_O  <= 64'h0000_0000_0000_0000;
			RD_VALID_O <= 1'b0;
		end else begin
			RD_VALID_O <= RD_I && !WR_I && EXT_SUPPORT_I && rd_hit;
			RD_DATA_O  <= (RD_I && !WR_I && EXT_SUPPORT_I && rd_hit) ? rd_mux : 64'h0000_0000_0000_0000;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			GP_FAULT_O <= 1'b0;
			GP_CODE_O  <= 32'h0000_0000;
		end else begin
			GP_FAULT_O <= WR_I || (RD_I && !(EXT_SUPPORT_I && rd_hit));
			GP_CODE_O  <= vmccc_pkg::GP_ERR_CODE;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			true_r <= 1'b0;
		end else begin
			true_r <= TRUE_CTL_I;
		end
	end

	// Capture vectors so the check sees a stable snapshot
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pin_ctl_r  <= 32'h0000_0000;
			pri_ctl_r  <= 32'h0000_0000;
			sec_ctl_r  <= 32'h0000_0000;
			exit_ctl_r <= 32'h0000_0000;
		end else if (ENTRY_REQ_I && state_r == vmccc_pkg::ST_IDLE) begin
			pin_ctl_r  <= PIN_CTL_I;
			pri_ctl_r  <= PRI_CTL_I;
			sec_ctl_r  <= SEC_CTL_I;
			exit_ctl_r <= EXIT_CTL_I;
		end
	end

	// Class wiring; true register replaces the base one when enabled
	assign cls[vmccc_pkg::CLS_PIN].ctl      = pin_ctl_r;
	assign cls[vmccc_pkg::CLS_PIN].cap      = true_r ? TRUE_PIN : pin_cap;
	assign cls[vmccc_pkg::CLS_PIN].def1     = vmccc_pkg::PIN_DEF1;
	assign cls[vmccc_pkg::CLS_PIN].true_en  = true_r;
	assign cls[vmccc_pkg::CLS_PIN].gate     = 1'b1;
	assign cls[vmccc_pkg::CLS_PRI].ctl      = pri_ctl_r;
	assign cls[vmccc_pkg::CLS_PRI].cap      = true_r ? TRUE_PRI : pri_cap;
	assign cls[vmccc_pkg::CLS_PRI].def1     = vmccc_pkg::PRI_DEF1;
	assign cls[vmccc_pkg::CLS_PRI].true_en  = true_r;
	assign cls[vmccc_pkg::CLS_PRI].gate     = 1'b1;
	assign cls[vmccc_pkg::CLS_SEC].ctl      = sec_ctl_r;
	assign cls[vmccc_pkg::CLS_SEC].cap      = sec_cap;
	assign cls[vmccc_pkg::CLS_SEC].def1     = 32'h0000_0000;
	assign cls[vmccc_pkg::CLS_SEC].true_en  = true_r;
	assign cls[vmccc_pkg::CLS_SEC].gate     = pri_ctl_r[vmccc_pkg::ACT_SEC_BIT];
	assign cls[vmccc_pkg::CLS_EXIT].ctl     = exit_ctl_r;
	assign cls[vmccc_pkg::CLS_EXIT].cap     = true_r ? TRUE_EXIT : exit_cap;
	assign cls[vmccc_pkg::CLS_EXIT].def1    = vmccc_pkg::EXIT_DEF1;
	assign cls[vmccc_pkg::CLS_EXIT].true_en = true_r;
	assign cls[vmccc_pkg::CLS_EXIT].gate    = 1'b1;

	genvar k;
	generate
		for (k = 0; k < vmccc_pkg::NCLS; k++) begin : g_cls
			vmccc_cls_check u_chk (
				.c (cls[k])
			);
			assign fail_vec[k] = cls[k].fail;
		end
	endgenerate

	// Entry sequencing: capture, check, report
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_r      <= vmccc_pkg::ST_IDLE;
			ENTRY_DONE_O <= 1'b0;
			ENTRY_FAIL_O <= 1'b0;
			FAIL_CLASS_O <= 4'h0;
			BUSY_O       <= 1'b0;
		end else begin
			ENTRY_DONE_O <= 1'b0;
			case (state_r)
				vmccc_pkg::ST_IDLE: begin
					if (ENTRY_REQ_I) begin
						state_r <= vmccc_pkg::ST_CHECK;
						BUSY_O  <= 1'b1;
					end
				end
				vmccc_pkg::ST_CHECK: begin
					ENTRY_FAIL_O <= |fail_vec;
					FAIL_CLASS_O <= fail_vec;
					ENTRY_DONE_O <= 1'b1;
					BUSY_O       <= 1'b0;
					state_r      <= vmccc_pkg::ST_IDLE;
				end
				default: begin
					state_r <= vmccc_pkg::ST_IDLE;
					BUSY_O  <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench: capability reads and entry checks
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] BP  = 64'h0000_007f_0000_0000;
	localparam logic [63:0] BR  = 64'hfff9_fffe_0000_0000;
	localparam logic [63:0] BX  = 64'h003f_ffff_0000_0000;
	localparam logic [63:0] TP  = 64'h0000_007f_0000_0001;
	localparam logic [63:0] SC  = 64'hffff_ffff_0000_0000;
	localparam logic [31:0] RSV = 32'hffff_ff00;
	logic        clk = 0, rst = 1, ext = 1, tf = 0, rd = 0, wr = 0, req = 0, rv, gf, dn, fl, bz;
	logic [11:0] idx = 0;
	logic [31:0] cp = 0, cr = 0, cs = 0, cx = 0, gc;
	logic [63:0] rdat;
	logic [3:0]  fc;
	int          mismatches = 0, check_count = 0;
	always #12.5 clk = ~clk;
	vmccc_top #(.PIN_CAP(BP), .PRI_CAP(BR), .SEC_CAP(SC), .EXIT_CAP(BX), .TRUE_PIN(TP), .TRUE_PRI(BR),
		.TRUE_EXIT(BX), .SEC_RSVD(RSV)) i_vmccc_top (
		.CLK_SYS_I(clk), .RST_I(rst), .EXT_SUPPORT_I(ext), .TRUE_CTL_I(tf), .RD_I(rd), .WR_I(wr), .IDX_I(idx),
		.RD_DATA_O(rdat), .RD_VALID_O(rv), .GP_FAULT_O(gf), .GP_CODE_O(gc), .ENTRY_REQ_I(req), .PIN_CTL_I(cp),
		.PRI_CTL_I(cr), .SEC_CTL_I(cs), .EXIT_CTL_I(cx), .ENTRY_DONE_O(dn), .ENTRY_FAIL_O(fl),
		.FAIL_CLASS_O(fc), .BUSY_O(bz));
	task tick;
		@(posedge clk);
		#2;
	endtask
	task cmp(string n, logic [127:0] e, logic [127:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic bad(logic [31:0] v, logic [63:0] c);
		return |(~v & c[31:0]) | |(v & ~c[63:32]);
	endfunction
	task rd_t(logic [11:0] i, logic w, logic [63:0] e, logic f);
		idx = i;
		rd = !w;
		wr = w;
		tick;
		rd = 0;
		wr = 0;
		cmp("read", {!f, f, f ? 64'h0 : e, 32'h0}, {rv, gf, rdat, gc});
		// Idle edge so the next call never re-drives rd in this step
		tick;
	endtask
	task en_t(logic [31:0] p, logic [31:0] r, logic [31:0] s, logic [31:0] x);
		logic [3:0] e;
		cp = p;
		cr = r;
		cs = s;
		cx = x;
		// Forced ones matter only without the true flag
		e[0] = bad(p, tf ? TP : BP | {32'h0, vmccc_pkg::PIN_DEF1});
		e[1] = bad(r, tf ? BR : BR | {32'h0, vmccc_pkg::PRI_DEF1});
		e[2] = r[31] & |(s & ~(SC[63:32] & ~RSV));
		e[3] = bad(x, tf ? BX : BX | {32'h0, vmccc_pkg::EXIT_DEF1});
		req = 1;
		tick;
		req = 0;
		cmp("busy", 1, bz);
		tick;
		cmp("entry", {1'b1, |e, e, 1'b0}, {dn, fl, fc, bz});
	endtask
	task t_reads;
		rd_t(12'h481, 0, BP | 64'h16, 0);
		rd_t(12'h482, 0, BR | {32'h0, vmccc_pkg::PRI_DEF1}, 0);
		rd_t(12'h483, 0, BX | {32'h0, vmccc_pkg::EXIT_DEF1}, 0);
		rd_t(12'h48b, 0, {SC[63:32] & ~RSV, 32'h0}, 0);
		for (int i = 13; i < 16; i++) rd_t(12'h480 + i[11:0], 0, 0, 1);
		rd_t(12'h484, 0, 0, 1);
		rd_t(12'h481, 1, 0, 1);
		ext = 0;
		rd_t(12'h482, 0, 0, 1);
		ext = 1;
		$display("test reads done");
	endtask
	task t_entry_base;
		en_t(32'h16, vmccc_pkg::PRI_DEF1, 0, vmccc_pkg::EXIT_DEF1);
		en_t(32'h14, vmccc_pkg::PRI_DEF1, 0, vmccc_pkg::EXIT_DEF1);
		en_t(32'h96, vmccc_pkg::PRI_DEF1, 0, vmccc_pkg::EXIT_DEF1);
		en_t(32'h16, 32'h0001_e172, 0, vmccc_pkg::EXIT_DEF1);
		en_t(32'h16, 32'h0401_e173, 0, 32'h0001_6dff);
		en_t(32'h16, vmccc_pkg::PRI_DEF1, 32'h100, vmccc_pkg::EXIT_DEF1);
		en_t(32'h16, 32'h8401_e172, 32'h100, vmccc_pkg::EXIT_DEF1);
		en_t(32'h16, 32'h8401_e172, 32'h80, vmccc_pkg::EXIT_DEF1);
		// Request held through busy cycle must be ignored
		cp = 32'h16;
		cr = vmccc_pkg::PRI_DEF1;
		cs = 0;
		cx = vmccc_pkg::EXIT_DEF1;
		req = 1;
		tick;
		cp = 32'h0;
		tick;
		cmp("held", 7'h40, {dn, fl, fc, bz});
		req = 0;
		tick;
		cmp("refused", 2'h0, {dn, bz});
		$display("test entry base done");
	endtask
	task t_true;
		tf = 1;
		tick;
		rd_t(12'h48d, 0, TP, 0);
		rd_t(12'h48e, 0, BR, 0);
		rd_t(12'h48f, 0, BX, 0);
		en_t(32'h1, 0, 0, 0);
		en_t(32'h0, 0, 0, 0);
		$display("test true done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#2;
		rst = 0;
		tick;
		t_reads;
		t_entry_base;
		t_true;
		final_report;
	end
	// Whole run is well under a hundred cycles
	initial begin
		repeat (2000) @(posedge clk);
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire

// >>> testbench/vmccc_props.sv
// Checker: capability read and entry-check properties
`default_nettype none
module vmccc_props #(
	parameter logic [31:0] SEC_RSVD = 32'hffff_ff00
) (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_I,
	input wire logic        EXT_SUPPORT_I,
	input wire logic        TRUE_CTL_I,
	input wire logic        RD_I,
	input wire logic        WR_I,
	input wire logic [11:0] IDX_I,
	input wire logic [63:0] RD_DATA_O,
	input wire logic        RD_VALID_O,
	input wire logic        GP_FAULT_O,
	input wire logic [31:0] GP_CODE_O,
	input wire logic        ENTRY_REQ_I,
	input wire logic [31:0] PRI_CTL_I,
	input wire logic        ENTRY_DONE_O,
	input wire logic        ENTRY_FAIL_O,
	input wire logic [3:0]  FAIL_CLASS_O,
	input wire logic        BUSY_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	logic rd_ok;
	assign rd_ok = RD_I && !WR_I && EXT_SUPPORT_I;
	property p_def(logic [11:0] i, logic [31:0] m);
		rd_ok && IDX_I == i |=> RD_VALID_O && (RD_DATA_O[31:0] & m) == m;
	endproperty
	a_pin_def_one: assert property (p_def(12'h481, vmccc_pkg::PIN_DEF1)) else $error("pin ones");
	a_pri_def_one: assert property (p_def(12'h482, vmccc_pkg::PRI_DEF1)) else $error("pri ones");
	a_exit_def_one: assert property (p_def(12'h483, vmccc_pkg::EXIT_DEF1)) else $error("exit ones");
	a_write_fault: assert property (WR_I |=> GP_FAULT_O && !RD_VALID_O && GP_CODE_O == 32'h0)
		else $error("write not faulted");
	a_noext_fault: assert property (RD_I && !EXT_SUPPORT_I |=> GP_FAULT_O) else $error("no fault");
	a_true_absent: assert property (rd_ok && !TRUE_CTL_I && !$past(TRUE_CTL_I)
		&& IDX_I[11:2] == 10'h123 && IDX_I[1:0] != 2'h0 |=> GP_FAULT_O && !RD_VALID_O) else $error("true read");
	a_sec_low_zero: assert property (rd_ok && IDX_I == 12'h48b |=> RD_DATA_O[31:0] == 32'h0
		&& (RD_DATA_O[63:32] & SEC_RSVD) == 32'h0) else $error("secondary bits");
	a_entry_walk: assert property (ENTRY_REQ_I && !BUSY_O |=> BUSY_O ##1 ENTRY_DONE_O && !BUSY_O)
		else $error("entry timing");
	a_fail_merge: assert property (ENTRY_DONE_O |-> ENTRY_FAIL_O == (FAIL_CLASS_O != 4'h0))
		else $error("fail merge");
	a_sec_gate: assert property (ENTRY_REQ_I && !BUSY_O && !PRI_CTL_I[31] |=> ##1 !FAIL_CLASS_O[2])
		else $error("secondary gate");
	c_fail: cover property (ENTRY_DONE_O && ENTRY_FAIL_O);
	c_pass: cover property (ENTRY_DONE_O && !ENTRY_FAIL_O);
	c_fault: cover property (GP_FAULT_O);
endmodule
bind vmccc_top vmccc_props #(.SEC_RSVD(SEC_RSVD)) i_vmccc_props (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
	.EXT_SUPPORT_I(EXT_SUPPORT_I), .TRUE_CTL_I(TRUE_CTL_I), .RD_I(RD_I), .WR_I(WR_I), .IDX_I(IDX_I),
	.RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .GP_FAULT_O(GP_FAULT_O), .GP_CODE_O(GP_CODE_O),
	.ENTRY_REQ_I(ENTRY_REQ_I), .PRI_CTL_I(PRI_CTL_I), .ENTRY_DONE_O(ENTRY_DONE_O),
	.ENTRY_FAIL_O(ENTRY_FAIL_O), .FAIL_CLASS_O(FAIL_CLASS_O), .BUSY_O(BUSY_O));
`default_nettype wire
